//--- verilog/crs_core_regs.sv
// crs_core_regs: dedicated register set of an 8-bit core, reached over
// avalon-mm, with flag generation, direct window and bank address mapping.
// assumes a synchronous avalon master on clk; one wait state per access.
`timescale 1ns/1ps

// Functional notes
// - 16-bit instruction pointer register
// - 16-bit accumulator, byte ops use low byte
// - 16-bit second accumulator, byte ops low byte
// - separate index, memory pointer, stack registers
// - status upper byte pointers, lower byte flags
// - direct pointer remaps only 0080 to 00FF
// - direct 0000 to 007F map to themselves
// - window maps to 0x80 times (n+1)
// - half carry from bit 3 to 4
// - interrupt enable flag, cleared by reset
// - accept request only below current level
// - negative flag follows result msb
// - zero flag set on zero result
// - overflow flag on two's complement overflow
// - carry out of bit 7, shift-out bit
// - 8-bit bank registers, eight each, 32 banks
// - low three opcode bits pick the register
// - one 64 kbyte address space
module crs_core_regs
   import crs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // interrupt acceptance
   input wire logic irq_req,
   input wire logic [1:0] irq_level,
   output logic irq_accept,
   // mapped addresses toward memory
   output logic [CRS_ADDR_W-1:0] direct_phys_addr,
   output logic [CRS_ADDR_W-1:0] bank_reg_addr
);

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: one wait state, answer on the second edge
   logic [CRS_REG_W-1:0] instruction_pointer_q;
   logic [CRS_REG_W-1:0] accumulator_q;
   logic [CRS_REG_W-1:0] temp_accumulator_q;
   logic [CRS_REG_W-1:0] index_modifier_q;
   logic [CRS_REG_W-1:0] extra_memory_pointer_q;
   logic [CRS_REG_W-1:0] stack_top_pointer_q;
   crs_status_t status_word_q;
   logic [15:0] alu_ctrl_q;
   logic [15:0] opcode_q;
   logic [15:0] direct_addr_q;
   logic [3:0] word_idx;
   logic req;
   logic ack_q;
   logic wr_fire;
   logic alu_fire;
   logic [15:0] wdata;
   logic [15:0] rd_mux;

   assign word_idx = avs_address[5:2];
   assign req = avs_read | avs_write;
   assign wr_fire = avs_write & ack_q;
   assign wdata = avs_writedata[15:0];

   // waitrequest high until the access is taken; the slave never stalls longer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_comb begin
      avs_waitrequest = ~ack_q;
   end

   // merge helper so byte lanes are honoured
   function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                         input logic [3:0] be);
      merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic: byte ops on low bytes of acc and temp
   crs_op_t alu_op;
   logic alu_word;
   logic [16:0] sum17;
   logic [8:0] sum9;
   logic [4:0] nib5;
   logic [15:0] res;
   logic res_c;
   logic res_h;
   logic res_v;
   logic res_n;
   logic res_z;
   logic [7:0] a8;
   logic [7:0] t8;

   assign alu_fire = wr_fire && (word_idx == CRS_IDX_ALU) && avs_byteenable[0];
   assign alu_word = wdata[3];
   assign a8 = accumulator_q[7:0];
   assign t8 = temp_accumulator_q[7:0];

   always_comb begin
      alu_op = CRS_OP_PASS;
      case (wdata[2:0])
         3'h0: alu_op = CRS_OP_ADD;
         3'h1: alu_op = CRS_OP_SUB;
         3'h2: alu_op = CRS_OP_SHL;
         3'h3: alu_op = CRS_OP_SHR;
         default: alu_op = CRS_OP_PASS;
      endcase
   end

   // on add and sub, c and h come from the low byte, even on word ops
   always_comb begin
      sum17 = 17'h00000;
      sum9 = 9'h000;
      nib5 = 5'h00;
      res = accumulator_q;
      res_c = status_word_q.condition_flags.c;
      res_h = status_word_q.condition_flags.h;
      res_v = status_word_q.condition_flags.v;
      case (alu_op)
         CRS_OP_ADD: begin
            sum17 = {1'b0, accumulator_q} + {1'b0, temp_accumulator_q};
            sum9 = {1'b0, a8} + {1'b0, t8};
            nib5 = {1'b0, a8[3:0]} + {1'b0, t8[3:0]};
            res = alu_word ? sum17[15:0] : {accumulator_q[15:8], sum9[7:0]};
            res_c = sum9[8];
            res_h = nib5[4];
            res_v = alu_word ? (accumulator_q[15] == temp_accumulator_q[15]) &&
                               (sum17[15] != accumulator_q[15])
                             : (a8[7] == t8[7]) && (sum9[7] != a8[7]);
         end
         CRS_OP_SUB: begin
            sum17 = {1'b0, accumulator_q} - {1'b0, temp_accumulator_q};
            sum9 = {1'b0, a8} - {1'b0, t8};
            nib5 = {1'b0, a8[3:0]} - {1'b0, t8[3:0]};
            res = alu_word ? sum17[15:0] : {accumulator_q[15:8], sum9[7:0]};
            res_c = sum9[8];
            res_h = nib5[4];
            res_v = alu_word ? (accumulator_q[15] != temp_accumulator_q[15]) &&
                               (sum17[15] != accumulator_q[15])
                             : (a8[7] != t8[7]) && (sum9[7] != a8[7]);
         end
         // shifts touch only the low byte; h and v keep their value
         CRS_OP_SHL: begin
            res = {accumulator_q[15:8], a8[6:0], 1'b0};
            res_c = a8[7];
         end
         CRS_OP_SHR: begin
            res = {accumulator_q[15:8], 1'b0, a8[7:1]};
            res_c = a8[0];
         end
         default: begin
            res = accumulator_q;
         end
      endcase
      res_n = alu_word ? res[15] : res[7];
      res_z = alu_word ? (res == 16'h0000) : (res[7:0] == 8'h00);
   end

   ////////////////////////////////////////////////////////////////////////////
   // dedicated registers, one process each; index, memory pointer and stack share one
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         instruction_pointer_q <= CRS_RST_WORD;
      end else if (wr_fire && word_idx == CRS_IDX_IP) begin
         instruction_pointer_q <= merge(instruction_pointer_q, wdata, avs_byteenable);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         accumulator_q <= CRS_RST_WORD;
      end else if (alu_fire) begin
         accumulator_q <= res;
      end else if (wr_fire && word_idx == CRS_IDX_ACC) begin
         accumulator_q <= merge(accumulator_q, wdata, avs_byteenable);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_accumulator_q <= CRS_RST_WORD;
      end else if (wr_fire && word_idx == CRS_IDX_TMP) begin
         temp_accumulator_q <= merge(temp_accumulator_q, wdata, avs_byteenable);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         index_modifier_q <= CRS_RST_WORD;
         extra_memory_pointer_q <= CRS_RST_WORD;
         stack_top_pointer_q <= CRS_RST_WORD;
      end else if (wr_fire) begin
         if (word_idx == CRS_IDX_IXM) begin
            index_modifier_q <= merge(index_modifier_q, wdata, avs_byteenable);
         end else if (word_idx == CRS_IDX_EMP) begin
            extra_memory_pointer_q <= merge(extra_memory_pointer_q, wdata, avs_byteenable);
         end else if (word_idx == CRS_IDX_STP) begin
            stack_top_pointer_q <= merge(stack_top_pointer_q, wdata, avs_byteenable);
         end
      end
   end

   // status word: flag update from arithmetic wins over a plain write of low byte
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_word_q <= CRS_RST_STW;
      end else if (alu_fire) begin
         status_word_q.condition_flags.c <= res_c;
         status_word_q.condition_flags.h <= res_h;
         status_word_q.condition_flags.v <= res_v;
         status_word_q.condition_flags.n <= res_n;
         status_word_q.condition_flags.z <= res_z;
      end else if (wr_fire && word_idx == CRS_IDX_STW) begin
         status_word_q <= merge(status_word_q, wdata, avs_byteenable);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alu_ctrl_q <= CRS_RST_WORD;
      end else if (alu_fire) begin
         alu_ctrl_q <= {12'h000, wdata[3:0]};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         opcode_q <= CRS_RST_WORD;
      end else if (wr_fire && word_idx == CRS_IDX_OPC) begin
         opcode_q <= merge(opcode_q, wdata, avs_byteenable);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         direct_addr_q <= CRS_RST_WORD;
      end else if (wr_fire && word_idx == CRS_IDX_DIR) begin
         direct_addr_q <= merge(direct_addr_q, wdata, avs_byteenable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address mapping within the 64 kbyte space
   logic [15:0] dir_map_d;
   logic [15:0] bank_addr_d;
   logic [2:0] dwp;

   assign dwp = status_word_q.direct_window_pointer;

   always_comb begin
      // only direct addresses 0080..00FF are steered by the pointer
      if (direct_addr_q[15:7] == 9'h001) begin
         dir_map_d = CRS_DIR_BLK * 16'({1'b0, dwp} + 4'h1) + {9'h000, direct_addr_q[6:0]};
      end else begin
         dir_map_d = direct_addr_q;
      end
   end

   // bank of eight byte registers lives in memory; opcode low bits pick one
   assign bank_addr_d = CRS_BANK_BASE
                        + {8'h00, status_word_q.bank_select_pointer, 3'h0}
                        + {13'h0000, opcode_q[2:0]};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         direct_phys_addr <= CRS_RST_WORD;
         bank_reg_addr <= CRS_BANK_BASE;
      end else begin
         direct_phys_addr <= dir_map_d;
         bank_reg_addr <= bank_addr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt gate: level 3 lets nothing through by an explicit check on cur_level
   logic [1:0] cur_level;
   logic irq_req_s1_q;
   logic irq_req_s2_q;
   logic [1:0] irq_level_s1_q;
   logic [1:0] irq_level_s2_q;

   assign cur_level = {status_word_q.condition_flags.il1, status_word_q.condition_flags.il0};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req_s1_q <= 1'b0;
         irq_req_s2_q <= 1'b0;
      end else begin
         irq_req_s1_q <= irq_req;
         irq_req_s2_q <= irq_req_s1_q;
      end
   end

   // level rides two flops of its own, as many as the request has, so the pair stays aligned
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_level_s1_q <= 2'h0;
         irq_level_s2_q <= 2'h0;
      end else begin
         irq_level_s1_q <= irq_level;
         irq_level_s2_q <= irq_level_s1_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_accept <= 1'b0;
      end else begin
         irq_accept <= irq_req_s2_q && status_word_q.condition_flags.i
                       && (irq_level_s2_q < cur_level) && (cur_level != 2'h3);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path, registered one edge before the answering edge
   always_comb begin
      if (word_idx == CRS_IDX_IP) begin
         rd_mux = instruction_pointer_q;
      end else if (word_idx == CRS_IDX_ACC) begin
         rd_mux = accumulator_q;
      end else if (word_idx == CRS_IDX_TMP) begin
         rd_mux = temp_accumulator_q;
      end else if (word_idx == CRS_IDX_IXM) begin
         rd_mux = index_modifier_q;
      end else if (word_idx == CRS_IDX_EMP) begin
         rd_mux = extra_memory_pointer_q;
      end else if (word_idx == CRS_IDX_STP) begin
         rd_mux = stack_top_pointer_q;
      end else if (word_idx == CRS_IDX_STW) begin
         rd_mux = status_word_q;
      end else if (word_idx == CRS_IDX_ALU) begin
         rd_mux = alu_ctrl_q;
      end else if (word_idx == CRS_IDX_OPC) begin
         rd_mux = opcode_q;
      end else if (word_idx == CRS_IDX_DIR) begin
         rd_mux = direct_addr_q;
      end else if (word_idx == CRS_IDX_IRQ) begin
         rd_mux = {14'h0000, cur_level};
      end else if (word_idx == CRS_IDX_MAP) begin
         rd_mux = dir_map_d;
      end else if (word_idx == CRS_IDX_BNK) begin
         rd_mux = bank_addr_d;
      end else begin
         rd_mux = CRS_UNMAPPED_RD;
      end
   end

   // readdata settles one edge early so it stands at the answering edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         avs_readdata <= {16'h0000, rd_mux};
      end
   end

endmodule

//--- common/crs_pkg.sv
// crs_pkg: constants, layouts and types of the core's dedicated register set.
// assumes one core clock; no other package is needed.
package crs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int CRS_REG_W = 16;
   localparam int CRS_ADDR_W = 16;

   // register word indices on the slave bus (byte address = index * 4)
   localparam logic [3:0] CRS_IDX_IP = 4'h0;
   localparam logic [3:0] CRS_IDX_ACC = 4'h1;
   localparam logic [3:0] CRS_IDX_TMP = 4'h2;
   localparam logic [3:0] CRS_IDX_IXM = 4'h3;
   localparam logic [3:0] CRS_IDX_EMP = 4'h4;
   localparam logic [3:0] CRS_IDX_STP = 4'h5;
   localparam logic [3:0] CRS_IDX_STW = 4'h6;
   localparam logic [3:0] CRS_IDX_ALU = 4'h7;
   localparam logic [3:0] CRS_IDX_OPC = 4'h8;
   localparam logic [3:0] CRS_IDX_DIR = 4'h9;
   localparam logic [3:0] CRS_IDX_IRQ = 4'hA;
   localparam logic [3:0] CRS_IDX_MAP = 4'hB;
   localparam logic [3:0] CRS_IDX_BNK = 4'hC;

   // reset values
   localparam logic [15:0] CRS_RST_WORD = 16'h0000;
   localparam logic [15:0] CRS_RST_STW = 16'h0000;

   // status word fields
   localparam int CRS_BSP_LSB = 11;
   localparam int CRS_DWP_LSB = 8;
   localparam int CRS_FLG_H = 6;
   localparam int CRS_FLG_I = 5;
   localparam int CRS_FLG_IL1 = 4;
   localparam int CRS_FLG_IL0 = 3;
   localparam int CRS_FLG_N = 2;
   localparam int CRS_FLG_Z = 1;
   localparam int CRS_FLG_V = 0;
   localparam int CRS_FLG_C = 7;

   // memory map of direct window and register banks
   localparam logic [15:0] CRS_DIR_WIN_BASE = 16'h0080;
   localparam logic [15:0] CRS_DIR_BLK = 16'h0080;
   localparam logic [15:0] CRS_BANK_BASE = 16'h0100;
   localparam int CRS_BANK_REGS = 8;

   // value returned for a read of an unmapped word
   localparam logic [15:0] CRS_UNMAPPED_RD = 16'h0000;

   typedef enum logic [2:0] {
      CRS_OP_ADD,
      CRS_OP_SUB,
      CRS_OP_SHL,
      CRS_OP_SHR,
      CRS_OP_PASS
   } crs_op_t;

   typedef struct packed {
      logic c;
      logic h;
      logic i;
      logic il1;
      logic il0;
      logic n;
      logic z;
      logic v;
   } crs_flags_t;

   typedef struct packed {
      logic [4:0] bank_select_pointer;
      logic [2:0] direct_window_pointer;
      crs_flags_t condition_flags;
   } crs_status_t;

endpackage

//--- dv/crs_core_regs_asserts.sv
// crs_core_regs_asserts: port checks of the dedicated register set.
// assumes binding to crs_core_regs; one clock, rst_b async active low.
`timescale 1ns/1ps
module crs_core_regs_asserts
   import crs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // slave bus
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // interrupt and mapping outputs
   input wire logic irq_req,
   input wire logic [1:0] irq_level,
   input wire logic irq_accept,
   input wire logic [CRS_ADDR_W-1:0] direct_phys_addr,
   input wire logic [CRS_ADDR_W-1:0] bank_reg_addr
);
////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
sequence ack_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
// four quiet samples cover the two sync flops plus the accept flop
sequence quiet_s; !irq_req [*4]; endsequence
// mapped outputs settle one edge after the write edge
sequence no_wr_s; !avs_write [*2]; endsequence

take_one_wait_a: assert property (req_s |=> ack_s)
   else $error("access not answered after exactly one wait state");
idle_wait_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
   else $error("wait released without a request");
rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
   else $error("read data moved without a read");
rd_upper_a: assert property (avs_readdata[31:16] == 16'h0000)
   else $error("read data upper half not zero");
bank_base_a: assert property (bank_reg_addr[15:8] == 8'h01)
   else $error("bank register address outside bank area");
map_hold_a: assert property (no_wr_s |=> $stable(direct_phys_addr) && $stable(bank_reg_addr))
   else $error("mapped address moved without a write");
irq_quiet_a: assert property (quiet_s |=> !irq_accept)
   else $error("interrupt accepted with no request");
irq_level_a: assert property (irq_accept |-> $past(irq_level, 3) <= 2'h1)
   else $error("interrupt accepted at a masked level");
endmodule

//--- dv/crs_core_regs_bench.sv
// crs_core_regs_bench: self-checking bench for the dedicated register set.
// assumes crs_pkg, crs_core_regs and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module crs_core_regs_bench
   import crs_pkg::*;
;
////////////////////////////////////////////////////////////////
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h0;
   logic irq_req = 1'b0;
   logic [1:0] irq_level = 2'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq_accept;
   logic [15:0] direct_phys_addr;
   logic [15:0] bank_reg_addr;
   int error_cnt = 0;
   int n_tests = 0;
   logic [15:0] m [16];
   logic [15:0] exp_q [$];
   logic [31:0] rd_exp;
   logic [3:0] idx;
   logic [15:0] d;
   crs_status_t st;
   always #12.5 clk = ~clk;

   crs_core_regs crs_core_regs_inst (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq_req(irq_req), .irq_level(irq_level),
      .irq_accept(irq_accept), .direct_phys_addr(direct_phys_addr),
      .bank_reg_addr(bank_reg_addr));
////////////////////////////////////////////////////////////////
   function automatic logic [15:0] dmap(input logic [15:0] a, input logic [2:0] p);
      if (a[15:7] != 9'h001 || p == 3'h0) return a;
      return ((16'(p) + 16'h0001) << 7) | {9'h000, a[6:0]};
   endfunction
   function automatic logic [15:0] exp_rd(input logic [3:0] i);
      crs_status_t s;
      s = m[6];
      case (i)
         CRS_IDX_IRQ: return {14'h0000, s.condition_flags.il1, s.condition_flags.il0};
         CRS_IDX_MAP: return dmap(m[9], s.direct_window_pointer);
         CRS_IDX_BNK: return 16'h0100 + {8'h00, s.bank_select_pointer, m[8][2:0]};
         4'hD, 4'hE, 4'hF: return 16'h0000;
         default: return m[i];
      endcase
   endfunction
   task automatic wait_ack();
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
   endtask
   task automatic bus_wr(input logic [3:0] i, input logic [15:0] v, input logic [3:0] be);
      avs_address <= {i, 2'h0};
      avs_writedata <= {16'h0000, v};
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
      @(posedge clk);
      // read-only and unmapped places keep their value
      if (i <= 4'h6 || i == 4'h8 || i == 4'h9) begin
         if (be[0]) m[i][7:0] = v[7:0];
         if (be[1]) m[i][15:8] = v[15:8];
      end
   endtask
   task automatic bus_rd(input logic [3:0] i);
      exp_q.push_back(exp_rd(i));
      avs_address <= {i, 2'h0};
      avs_read <= 1'b1;
      wait_ack();
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic alu(input logic [2:0] op, input logic w);
      logic [15:0] av, tv, tb, r;
      logic [8:0] s;
      logic [4:0] hs;
      crs_status_t sw;
      crs_flags_t f;
      av = m[1];
      tv = m[2];
      sw = m[6];
      f = sw.condition_flags;
      tb = (op == 3'h1) ? ~tv : tv;
      s = (op == 3'h1) ? {1'b0, av[7:0]} - {1'b0, tv[7:0]} : {1'b0, av[7:0]} + {1'b0, tv[7:0]};
      hs = (op == 3'h1) ? {1'b0, av[3:0]} - {1'b0, tv[3:0]} : {1'b0, av[3:0]} + {1'b0, tv[3:0]};
      r = (op == 3'h1) ? av - tv : av + tv;
      if (op[1]) begin
         f.c = op[0] ? av[0] : av[7];
         r = {av[15:8], op[0] ? {1'b0, av[7:1]} : {av[6:0], 1'b0}};
      end else begin
         f.c = s[8];
         f.h = hs[4];
         if (!w) r[15:8] = av[15:8];
         f.v = w ? (av[15] == tb[15] && r[15] != av[15]) : (av[7] == tb[7] && r[7] != av[7]);
      end
      f.n = w ? r[15] : r[7];
      f.z = w ? (r == 16'h0000) : (r[7:0] == 8'h00);
      sw.condition_flags = f;
      bus_wr(CRS_IDX_ALU, {12'h000, w, op}, 4'h3);
      m[1] = r;
      m[6] = sw;
      m[7] = {12'h000, w, op};
   endtask
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
////////////////////////////////////////////////////////////////
   // read results are checked in order of issue
   always @(posedge clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         rd_exp = {16'h0000, exp_q.pop_front()};
         `CHK(avs_readdata, rd_exp)
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      end_sim();
   end
   initial begin
      void'($urandom(32'hE9BC11BC));
      m = '{default: 16'h0000};
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 16; i++) bus_rd(4'(i));
      for (int i = 0; i < 40; i++) begin
         idx = 4'($urandom_range(15, 0));
         if (idx == 4'h7) idx = 4'hD;
         d = 16'($urandom);
         if (idx == 4'h9) d[15:8] = 8'h00;
         bus_wr(idx, d, 4'($urandom));
         bus_rd(idx);
      end
      // fixed operands first hit carry, half carry, zero and overflow
      for (int i = 0; i < 24; i++) begin
         bus_wr(CRS_IDX_ACC, i < 6 ? 16'h7FFF : 16'($urandom), 4'h3);
         bus_wr(CRS_IDX_TMP, i < 6 ? 16'h0001 : 16'($urandom), 4'h3);
         bus_wr(CRS_IDX_STW, 16'($urandom), 4'h3);
         alu(3'(i % 4), (i % 8) > 3);
         bus_rd(CRS_IDX_ALU);
         bus_rd(CRS_IDX_ACC);
         bus_rd(CRS_IDX_STW);
      end
      for (int i = 0; i < 16; i++) begin
         st = crs_status_t'(16'($urandom));
         st.direct_window_pointer = 3'(i / 2);
         bus_wr(CRS_IDX_STW, st, 4'h3);
         bus_wr(CRS_IDX_DIR, {8'h00, i[0], 7'($urandom)}, 4'h3);
         bus_wr(CRS_IDX_OPC, 16'($urandom), 4'h3);
         bus_rd(CRS_IDX_MAP);
         bus_rd(CRS_IDX_BNK);
         `CHK(direct_phys_addr, exp_rd(CRS_IDX_MAP))
         `CHK(bank_reg_addr, exp_rd(CRS_IDX_BNK))
         bus_wr(CRS_IDX_DIR, 16'($urandom) | 16'h0100, 4'h3);
         bus_rd(CRS_IDX_MAP);
         `CHK(direct_phys_addr, exp_rd(CRS_IDX_MAP))
      end
      for (int i = 0; i < 32; i++) begin
         st = '0;
         st.condition_flags.i = i[4];
         {st.condition_flags.il1, st.condition_flags.il0} = i[3:2];
         bus_wr(CRS_IDX_STW, st, 4'h3);
         bus_rd(CRS_IDX_IRQ);
         irq_level <= i[1:0];
         irq_req <= 1'b1;
         repeat (5) @(posedge clk);
         `CHK(irq_accept, i[4] && i[3:2] != 2'h3 && i[1:0] < i[3:2])
         irq_req <= 1'b0;
         repeat (5) @(posedge clk);
      end
      // second reset with an accepted request pending
      bus_wr(CRS_IDX_STW, 16'h0030, 4'h3);
      irq_level <= 2'h0;
      irq_req <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(irq_accept, 1'b1)
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      m = '{default: 16'h0000};
      repeat (5) @(posedge clk);
      `CHK(irq_accept, 1'b0)
      bus_rd(CRS_IDX_STW);
      irq_req <= 1'b0;
      end_sim();
   end
endmodule

bind crs_core_regs crs_core_regs_asserts crs_core_regs_asserts_inst (.clk(clk), .rst_b(rst_b),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq_req(irq_req), .irq_level(irq_level),
   .irq_accept(irq_accept), .direct_phys_addr(direct_phys_addr),
   .bank_reg_addr(bank_reg_addr));
